//--- rtl/trim_pkg.sv
// Overview of operation
// (RULE1) remote power found bit reports discovered terminal
// (RULE2) power found only valid with autoneg enabled
// (RULE3) standard partner bit set on ordinary partner
// (RULE4) reading register clears partner and timer bits
// (RULE5) timer bit set on expiry with partner
// (RULE6) software ignores timer bit without partner bit
// (RULE7) two low bits reserved, read zero
// (RULE8) strap defaults sampled at every hardware reset
// (RULE9) rise time field resets from edge straps
// (RULE10) auto crossover enable resets from its strap
// (RULE11) crossover select resets from its strap
// (RULE12) discovery runs only while enable bit set
// (RULE13) select ignored under auto crossover; swaps pairs
package trim_pkg;
    localparam logic [4:0] TRIM_REG_ADDR = 5'h1b;
    localparam int PREAMBLE_LEN = 32;
    localparam int ADDR_BITS = 10;
    localparam int DATA_BITS = 16;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam int RISE_LO = 10;
    localparam int AUTO_XOVER_BIT = 9;
    localparam int XOVER_BIT = 8;
    localparam int ANALOG_LOOP_BIT = 7;
    localparam int DISC_EN_BIT = 6;
    localparam int SPEEDUP_BIT = 5;
    localparam int POWER_FOUND_BIT = 4;
    localparam int PARTNER_BIT = 3;
    localparam int TIMER_BIT = 2;
    localparam logic ANALOG_LOOP_RST = 1'b0;
    localparam logic DISC_EN_RST = 1'b0;
    localparam logic SPEEDUP_RST = 1'b0;
    localparam logic [15:0] READ_IMAGE_ZERO = 16'h0000;
    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_START = 6'h02,
        ST_OP    = 6'h04,
        ST_ADDR  = 6'h08,
        ST_TA    = 6'h10,
        ST_DATA  = 6'h20
    } frame_state_t;
endpackage

//--- rtl/sticky_flag.sv
`timescale 1ns/1ps
module sticky_flag (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // event and clear
    input wire logic set,
    input wire logic clear,
    // held flag
    output logic flag
);
    // set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            flag <= 1'b0;
        end else if (set) begin
            flag <= 1'b1;
        end else if (clear) begin
            flag <= 1'b0;
        end
    end
endmodule

//--- rtl/dte_discovery_status_bits.sv
`timescale 1ns/1ps
module dte_discovery_status_bits (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // management serial port
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe_n,
    input wire logic [4:0] phy_addr,
    // strap pins
    input wire logic [1:0] tx_edge_rate_straps,
    input wire logic auto_crossover_strap,
    input wire logic crossover_strap,
    // discovery and link status
    input wire logic auto_neg_enable,
    input wire logic remote_power_found_in,
    input wire logic standard_partner_evt,
    input wire logic inhibit_timer_evt,
    input wire logic link_established,
    input wire logic auto_crossover_swap,
    // control and status outputs
    output logic [1:0] tx_rise_time,
    output logic auto_crossover_enable,
    output logic crossover_select,
    output logic analog_loopback,
    output logic loopback_speedup,
    output logic discovery_enable,
    output logic tx_on_pair_b,
    output logic remote_power_found,
    output logic standard_partner_found,
    output logic inhibit_timer_expired
);
    trim_pkg::frame_state_t state;
    logic mdc_q;
    logic mdc_rise;
    logic [5:0] pre_cnt;
    logic [4:0] bit_cnt;
    logic [1:0] op;
    logic [9:0] addr_shift;
    logic [15:0] shift;
    logic hit;
    logic rd_clear;
    logic wr_stb;
    logic [15:0] wr_data;
    logic [15:0] read_image;
    logic [1:0] flag_set;
    logic [1:0] flag_clr;
    logic [1:0] flags;

    assign mdc_rise = mdc & ~mdc_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            mdc_q <= 1'b0;
        end else begin
            mdc_q <= mdc;
        end
    end

    // (RULE7) reserved bits read zero
    always_comb begin
        read_image = trim_pkg::READ_IMAGE_ZERO;
        read_image[trim_pkg::RISE_LO +: 2] = tx_rise_time;
        read_image[trim_pkg::AUTO_XOVER_BIT] = auto_crossover_enable;
        read_image[trim_pkg::XOVER_BIT] = crossover_select;
        read_image[trim_pkg::ANALOG_LOOP_BIT] = analog_loopback;
        read_image[trim_pkg::DISC_EN_BIT] = discovery_enable;
        read_image[trim_pkg::SPEEDUP_BIT] = loopback_speedup;
        read_image[trim_pkg::POWER_FOUND_BIT] = remote_power_found;
        read_image[trim_pkg::PARTNER_BIT] = standard_partner_found;
        read_image[trim_pkg::TIMER_BIT] = inhibit_timer_expired;
    end

    // frame engine, sampling and driving on mdc rise
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= trim_pkg::ST_IDLE;
            pre_cnt <= 6'h00;
            bit_cnt <= 5'h00;
            op <= 2'h0;
            addr_shift <= 10'h000;
            shift <= 16'h0000;
            hit <= 1'b0;
            rd_clear <= 1'b0;
            wr_stb <= 1'b0;
            wr_data <= 16'h0000;
            mdio_out <= 1'b1;
            mdio_oe_n <= 1'b1;
        end else begin
            rd_clear <= 1'b0;
            wr_stb <= 1'b0;
            if (mdc_rise) begin
                case (state)
                    trim_pkg::ST_IDLE: begin
                        if (mdio_in) begin
                            if (pre_cnt != 6'(trim_pkg::PREAMBLE_LEN)) begin
                                pre_cnt <= pre_cnt + 6'h01;
                            end
                        end else begin
                            if (pre_cnt == 6'(trim_pkg::PREAMBLE_LEN)) begin
                                state <= trim_pkg::ST_START;
                            end
                            pre_cnt <= 6'h00;
                        end
                    end
                    trim_pkg::ST_START: begin
                        bit_cnt <= 5'h00;
                        state <= mdio_in ? trim_pkg::ST_OP : trim_pkg::ST_IDLE;
                    end
                    trim_pkg::ST_OP: begin
                        op <= {op[0], mdio_in};
                        bit_cnt <= bit_cnt + 5'h01;
                        if (bit_cnt == 5'h01) begin
                            bit_cnt <= 5'h00;
                            if ({op[0], mdio_in} == trim_pkg::OP_READ ||
                                {op[0], mdio_in} == trim_pkg::OP_WRITE) begin
                                state <= trim_pkg::ST_ADDR;
                            end else begin
                                state <= trim_pkg::ST_IDLE;
                            end
                        end
                    end
                    trim_pkg::ST_ADDR: begin
                        addr_shift <= {addr_shift[8:0], mdio_in};
                        bit_cnt <= bit_cnt + 5'h01;
                        if (bit_cnt == 5'(trim_pkg::ADDR_BITS - 1)) begin
                            bit_cnt <= 5'h00;
                            state <= trim_pkg::ST_TA;
                            hit <= (addr_shift[8:4] == phy_addr) &&
                                   ({addr_shift[3:0], mdio_in} == trim_pkg::TRIM_REG_ADDR);
                            if ((addr_shift[8:4] == phy_addr) &&
                                ({addr_shift[3:0], mdio_in} == trim_pkg::TRIM_REG_ADDR) &&
                                op == trim_pkg::OP_READ) begin
                                // (RULE4) snapshot then clear on read
                                shift <= read_image;
                                rd_clear <= 1'b1;
                            end
                        end
                    end
                    trim_pkg::ST_TA: begin
                        bit_cnt <= bit_cnt + 5'h01;
                        if (bit_cnt == 5'h00) begin
                            if (hit && op == trim_pkg::OP_READ) begin
                                mdio_out <= 1'b0;
                                mdio_oe_n <= 1'b0;
                            end
                        end else begin
                            bit_cnt <= 5'h00;
                            state <= trim_pkg::ST_DATA;
                            if (hit && op == trim_pkg::OP_READ) begin
                                mdio_out <= shift[15];
                                shift <= {shift[14:0], 1'b0};
                            end
                        end
                    end
                    trim_pkg::ST_DATA: begin
                        bit_cnt <= bit_cnt + 5'h01;
                        if (op == trim_pkg::OP_READ) begin
                            mdio_out <= shift[15];
                            shift <= {shift[14:0], 1'b0};
                        end else begin
                            shift <= {shift[14:0], mdio_in};
                        end
                        if (bit_cnt == 5'(trim_pkg::DATA_BITS - 1)) begin
                            state <= trim_pkg::ST_IDLE;
                            pre_cnt <= 6'h00;
                            mdio_out <= 1'b1;
                            mdio_oe_n <= 1'b1;
                            if (hit && op == trim_pkg::OP_WRITE) begin
                                wr_stb <= 1'b1;
                                wr_data <= {shift[14:0], mdio_in};
                            end
                        end
                    end
                    default: begin
                        state <= trim_pkg::ST_IDLE;
                        pre_cnt <= 6'h00;
                        mdio_oe_n <= 1'b1;
                    end
                endcase
            end
        end
    end

    // writable fields; straps reload on every reset
    always_ff @(posedge clk) begin
        if (rst) begin
            // (RULE8) strap sampling at reset
            // (RULE9) rise time from straps
            tx_rise_time <= tx_edge_rate_straps;
            // (RULE10) auto crossover from strap
            auto_crossover_enable <= auto_crossover_strap;
            // (RULE11) select from strap
            crossover_select <= crossover_strap;
            analog_loopback <= trim_pkg::ANALOG_LOOP_RST;
            // (RULE12) discovery off after reset
            discovery_enable <= trim_pkg::DISC_EN_RST;
            loopback_speedup <= trim_pkg::SPEEDUP_RST;
        end else if (wr_stb) begin
            tx_rise_time <= wr_data[trim_pkg::RISE_LO +: 2];
            auto_crossover_enable <= wr_data[trim_pkg::AUTO_XOVER_BIT];
            crossover_select <= wr_data[trim_pkg::XOVER_BIT];
            analog_loopback <= wr_data[trim_pkg::ANALOG_LOOP_BIT];
            discovery_enable <= wr_data[trim_pkg::DISC_EN_BIT];
            loopback_speedup <= wr_data[trim_pkg::SPEEDUP_BIT];
        end
    end

    // (RULE13) effective pair selection
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_on_pair_b <= 1'b0;
        end else begin
            tx_on_pair_b <= auto_crossover_enable ? auto_crossover_swap : crossover_select;
        end
    end

    // (RULE1) power found gated by enables
    // (RULE2) needs autoneg enabled
    always_ff @(posedge clk) begin
        if (rst) begin
            remote_power_found <= 1'b0;
        end else begin
            remote_power_found <= remote_power_found_in & auto_neg_enable & discovery_enable;
        end
    end

    // (RULE3) partner set on event
    // (RULE5) timer set only with partner seen
    assign flag_set[0] = standard_partner_evt & discovery_enable;
    // partner term from the live flag, so a read that just cleared it is honoured
    assign flag_set[1] = inhibit_timer_evt & discovery_enable &
                         ((flags[0] & ~flag_clr[0]) | flag_set[0]);
    assign flag_clr[0] = rd_clear;
    assign flag_clr[1] = rd_clear | link_established;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_flag
            sticky_flag u_flag (
                .clk(clk),
                .rst(rst),
                .set(flag_set[gi]),
                .clear(flag_clr[gi]),
                .flag(flags[gi])
            );
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            standard_partner_found <= 1'b0;
            inhibit_timer_expired <= 1'b0;
        end else begin
            standard_partner_found <= flags[0];
            inhibit_timer_expired <= flags[1];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    power_set_a: assert property ( // RULE1
        !$past(rst) && $past(remote_power_found_in && auto_neg_enable && discovery_enable)
        |-> remote_power_found)
        else $error("power found not reported");
    power_gate_a: assert property ( // RULE2
        !$past(rst) && remote_power_found |-> $past(auto_neg_enable))
        else $error("power found without autoneg");
    partner_set_a: assert property ( // RULE3
        standard_partner_evt && discovery_enable |-> ##2 standard_partner_found)
        else $error("partner event lost");
    read_clear_a: assert property ( // RULE4
        rd_clear && !standard_partner_evt && !inhibit_timer_evt
        |-> ##2 !standard_partner_found && !inhibit_timer_expired)
        else $error("flags not cleared by read");
    timer_pair_a: assert property ( // RULE5
        inhibit_timer_expired |-> standard_partner_found)
        else $error("timer flag without partner");
    reserved_zero_a: assert property ( // RULE7
        rd_clear |-> shift[1:0] == 2'h0 && shift[15:12] == 4'h0)
        else $error("reserved bits nonzero");
    strap_rise_a: assert property ( // RULE9
        $past(rst) |-> tx_rise_time == $past(tx_edge_rate_straps))
        else $error("rise time strap not loaded");
    strap_auto_a: assert property ( // RULE10
        $past(rst) |-> auto_crossover_enable == $past(auto_crossover_strap))
        else $error("auto crossover strap not loaded");
    strap_xover_a: assert property ( // RULE11
        $past(rst) |-> crossover_select == $past(crossover_strap))
        else $error("crossover strap not loaded");
    disc_reset_a: assert property ( // RULE12
        $past(rst) |-> !discovery_enable ##1 !standard_partner_found)
        else $error("discovery not off after reset");
    pair_sel_a: assert property ( // RULE13
        !$past(rst) && !$past(auto_crossover_enable)
        |-> tx_on_pair_b == $past(crossover_select))
        else $error("manual pair select ignored");
endmodule

//--- test/mdio_host.sv
`timescale 1ns/1ps
module mdio_host (
    // clock
    input wire logic clk,
    // management line
    input wire logic line,
    output logic mdc,
    output logic drv,
    output logic drv_en
);
    initial begin
        mdc = 1'b0;
        drv = 1'b1;
        drv_en = 1'b0;
    end

    // one bit: mdc low four clocks, then high four clocks
    task automatic bit_x(input logic b, input logic en, output logic s);
        drv <= b;
        drv_en <= en;
        repeat (4) @(posedge clk);
        s = line;
        mdc <= 1'b1;
        repeat (4) @(posedge clk);
        mdc <= 1'b0;
    endtask

    task automatic frame(input logic rd, input logic [4:0] ph, input logic [15:0] wd,
            output logic [15:0] q);
        logic [47:0] hdr;
        logic s;
        hdr = {32'hffff_ffff, 2'b01, rd, !rd, ph, trim_pkg::TRIM_REG_ADDR, 2'b10};
        for (int i = 47; i >= 0; i--) begin
            bit_x(hdr[i], !(rd && i < 2), s);
        end
        for (int i = 15; i >= 0; i--) begin
            bit_x(wd[i] & (i > 1), !rd, s);
            q[i] = s;
        end
    endtask
endmodule

//--- test/tb.sv
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic an;
        logic rp;
        logic sw;
        logic [1:0] ctl;
        logic pf;
        logic pair;
    } row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] straps = 2'b10;
    logic auto_strap = 1'b0;
    logic cross_strap = 1'b1;
    logic an = 1'b0;
    logic rp_in = 1'b0;
    logic swap = 1'b0;
    logic sp_evt = 1'b0;
    logic it_evt = 1'b0;
    logic link_evt = 1'b0;
    logic mdc, drv, drv_en, mdio_out, mdio_oe_n, line;
    logic [1:0] rise;
    logic ae, xs, al, ls, de, pair_b, pf, spf, ite;
    logic [15:0] q;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;
    row_t rows [4] = '{'{1, 1, 0, 2'b00, 1, 0}, '{0, 1, 1, 2'b01, 0, 1},
        '{1, 0, 1, 2'b10, 0, 1}, '{1, 1, 0, 2'b11, 1, 0}};

    always #12.5 clk = ~clk;
    // released line is pulled up
    assign line = !mdio_oe_n ? mdio_out : (drv_en ? drv : 1'b1);

    mdio_host host (.clk(clk), .line(line), .mdc(mdc), .drv(drv), .drv_en(drv_en));

    dte_discovery_status_bits uut (.clk(clk), .rst(rst), .mdc(mdc), .mdio_in(line),
        .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .phy_addr(5'h03),
        .tx_edge_rate_straps(straps), .auto_crossover_strap(auto_strap),
        .crossover_strap(cross_strap), .auto_neg_enable(an), .remote_power_found_in(rp_in),
        .standard_partner_evt(sp_evt), .inhibit_timer_evt(it_evt),
        .link_established(link_evt), .auto_crossover_swap(swap), .tx_rise_time(rise),
        .auto_crossover_enable(ae), .crossover_select(xs), .analog_loopback(al),
        .loopback_speedup(ls), .discovery_enable(de), .tx_on_pair_b(pair_b),
        .remote_power_found(pf), .standard_partner_found(spf), .inhibit_timer_expired(ite));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] d);
        host.frame(1'b0, 5'h03, d, q);
    endtask

    task automatic rd_chk(input logic [15:0] e);
        host.frame(1'b1, 5'h03, 16'h0000, q);
        chk(q, e);
    endtask

    // one-cycle pulse on {link, timer, partner}, then settle
    task automatic pulse(input logic [2:0] m);
        {link_evt, it_evt, sp_evt} <= m;
        @(posedge clk);
        {link_evt, it_evt, sp_evt} <= 3'b000;
        repeat (3) @(posedge clk);
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({12'h000, rise, ae, xs}, 16'h0009);
        rd_chk(16'h0900);
        $display("strap defaults done");
        foreach (rows[i]) begin
            an <= rows[i].an;
            rp_in <= rows[i].rp;
            swap <= rows[i].sw;
            wr({6'h00, rows[i].ctl, 8'h40});
            chk({12'h000, pf, pair_b, ae, xs}, {12'h000, rows[i].pf, rows[i].pair, rows[i].ctl});
            rd_chk({6'h00, rows[i].ctl, 3'b010, rows[i].pf, 4'h0});
        end
        $display("row table done");
        an <= 1'b0;
        wr(16'hffff);
        chk({13'h0000, al, ls, de}, 16'h0007);
        rd_chk(16'h0fe0);
        $display("write mask done");
        wr(16'h0040);
        pulse(3'b010);
        chk({14'h0000, spf, ite}, 16'h0000);
        pulse(3'b001);
        pulse(3'b010);
        chk({14'h0000, spf, ite}, 16'h0003);
        rd_chk(16'h004c);
        rd_chk(16'h0040);
        pulse(3'b011);
        pulse(3'b100);
        chk({14'h0000, spf, ite}, 16'h0002);
        rd_chk(16'h0048);
        wr(16'h0000);
        pulse(3'b011);
        chk({14'h0000, spf, ite}, 16'h0000);
        $display("flags done");
        host.frame(1'b0, 5'h04, 16'h0300, q);
        host.frame(1'b1, 5'h04, 16'h0000, q);
        chk(q, 16'hffff);
        rd_chk(16'h0000);
        $display("foreign address done");
        rst <= 1'b1;
        straps <= 2'b01;
        auto_strap <= 1'b1;
        cross_strap <= 1'b0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_chk(16'h0600);
        $display("second reset done");
        tally_and_finish();
    end
endmodule
